/* File: boot_map.sv */
// Works out reset address, vector addresses and execution region.
// Assumes static fuse settings and a word program counter from the core.
`timescale 1ns/10ps
`default_nettype none
module boot_map #(
    parameter int unsigned FLASH_WORDS = ivr_pkg::FLASH_WORDS_DEF,
    parameter int unsigned BOOT_MIN_WORDS = ivr_pkg::BOOT_MIN_WORDS_DEF
) (
    input wire logic mclk,
    input wire logic reset,
    input wire ivr_pkg::fuse_s fuses,
    input wire logic select,
    input wire logic [ivr_pkg::PC_W-1:0] exec_pc,
    input wire logic [ivr_pkg::INDEX_W-1:0] vector_index,
    output ivr_pkg::map_s map_q
);

    localparam int unsigned W = ivr_pkg::PC_W;

    if (FLASH_WORDS > (1 << W) || (BOOT_MIN_WORDS << 3) >= FLASH_WORDS) begin
        $error("Flash or boot area size does not fit the address width.");
    end

    // Boot area start; fewer programmed size fuses mean a larger area.
    function automatic logic [W-1:0] boot_start_of(input logic [1:0] sz);
        logic [W:0] span;
        span = (W+1)'(BOOT_MIN_WORDS) << (~sz);
        return W'((W+1)'(FLASH_WORDS) - span);
    endfunction

    logic [W-1:0] boot_start;
    logic [W-1:0] base;

    assign boot_start = boot_start_of(fuses.boot_size_fuses);
    assign base = select ? boot_start : ivr_pkg::ADDR_ZERO;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            map_q <= ivr_pkg::MAP_RESET;
        end else begin
            map_q.reset_addr <= fuses.boot_reset_fuse ? boot_start
                : ivr_pkg::ADDR_ZERO;
            map_q.vector_base <= base;
            map_q.vector_addr <= base + W'({vector_index, 1'b0});
            map_q.in_boot <= (exec_pc >= boot_start);
        end
    end

endmodule
`default_nettype wire

/* File: core_model.sv */
// Behavioural processor core stepping its fetch address in one region.
// Assumes the bench picks the region, interrupt number and global flag.
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run_in_boot,
    input wire logic irq_on,
    input wire logic [4:0] irq_num,
    input wire logic [12:0] boot_start,
    output logic [12:0] exec_pc,
    output logic [4:0] vector_index,
    output logic global_irq_enable
);
    logic [3:0] step_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            step_q <= 4'h0;
            exec_pc <= 13'h0000;
            vector_index <= 5'h00;
            global_irq_enable <= 1'b0;
        end else begin
            step_q <= step_q + 4'h1;
            exec_pc <= (run_in_boot ? boot_start : 13'h0100) + 13'(step_q);
            vector_index <= irq_num;
            global_irq_enable <= irq_on;
        end
    end
endmodule
`default_nettype wire

/* File: ivr_monitor.sv */
// Checker for the vector placement block, bound to its top ports.
// Assumes fuses only change while reset is high.
`timescale 1ns/10ps
`default_nettype none
module ivr_monitor #(
    parameter int unsigned FLASH_WORDS = 8192,
    parameter int unsigned BOOT_MIN_WORDS = 128
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire ivr_pkg::fuse_s fuses,
    input wire logic global_irq_enable,
    input wire logic [12:0] exec_pc,
    input wire logic [4:0] vector_index,
    input wire logic dispatch_allow_q,
    input wire logic [12:0] reset_vector_addr,
    input wire logic [12:0] vector_base_addr,
    input wire logic [12:0] vector_addr
);
    logic [1:0] up_q;
    logic [12:0] bs;
    logic wr, arm, up, lk_app, lk_boot;
    assign bs = 13'(FLASH_WORDS -
        (BOOT_MIN_WORDS << (2'h3 - fuses.boot_size_fuses)));
    assign wr = psel && penable && pready && pwrite &&
        paddr == ivr_pkg::GIC_OFFSET;
    assign arm = wr && pwdata[ivr_pkg::UNLOCK_BIT];
    assign up = up_q == 2'h3;
    assign lk_app = fuses.app_area_boot_lock && vector_base_addr != 0 &&
        exec_pc < bs;
    assign lk_boot = fuses.boot_area_boot_lock && vector_base_addr == 0 &&
        exec_pc >= bs;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            up_q <= 2'h0;
        end else if (!up) begin
            up_q <= up_q + 2'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_arm;
        arm |=> !dispatch_allow_q [*4];
    endproperty
    a_arm: assert property (p_arm) else $error("not held off");
    property p_resume;
        arm && !fuses.app_area_boot_lock && !fuses.boot_area_boot_lock
        ##1 (!psel && global_irq_enable) [*6] |-> dispatch_allow_q;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_gie;
        !$past(global_irq_enable) |-> !dispatch_allow_q;
    endproperty
    a_gie: assert property (p_gie) else $error("flag ignored");
    property p_lk_app;
        up && vector_base_addr != 13'h0000 && $past(lk_app) &&
        $past(lk_app, 2) |-> !dispatch_allow_q;
    endproperty
    a_lk_app: assert property (p_lk_app) else $error("app lock");
    property p_lk_boot;
        up && vector_base_addr == 13'h0000 && $past(lk_boot) &&
        $past(lk_boot, 2) |-> !dispatch_allow_q;
    endproperty
    a_lk_boot: assert property (p_lk_boot) else $error("boot lock");
    property p_vec;
        ($stable(vector_index) && $stable(vector_base_addr)) [*2] |->
        vector_addr == vector_base_addr + {vector_index, 1'b0};
    endproperty
    a_vec: assert property (p_vec) else $error("vector addr");
    property p_rst;
        up |-> reset_vector_addr == (fuses.boot_reset_fuse ? bs : 13'h0);
    endproperty
    a_rst: assert property (p_rst) else $error("reset addr");
    property p_move;
        up && $changed(vector_base_addr) |->
        $past(wr) || $past(wr, 2) || $past(wr, 3);
    endproperty
    a_move: assert property (p_move) else $error("base moved");
endmodule
`default_nettype wire

/* File: ivr_pkg.sv */
// Shared constants and types for the interrupt vector placement block.
// Assumes a word-addressed program flash and an APB register bus.
package ivr_pkg;

    localparam int unsigned PC_W = 13;
    localparam int unsigned INDEX_W = 5;
    localparam int unsigned FLASH_WORDS_DEF = 8192;
    localparam int unsigned BOOT_MIN_WORDS_DEF = 128;

    localparam logic [11:0] GIC_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] FAULT_OFFSET = 12'h008;

    localparam int unsigned UNLOCK_BIT = 0;
    localparam int unsigned SELECT_BIT = 1;
    localparam int unsigned INT2_EN_BIT = 5;
    localparam int unsigned INT0_EN_BIT = 6;
    localparam int unsigned INT1_EN_BIT = 7;
    localparam logic [7:0] GIC_RESET = 8'h00;

    localparam int unsigned ST_BLOCK_BIT = 0;
    localparam int unsigned ST_SEQ_BIT = 1;
    localparam int unsigned ST_LOCK_BIT = 2;
    localparam int unsigned ST_IN_BOOT_BIT = 3;
    localparam int unsigned ST_BOOT_RESET_BIT = 4;
    localparam int unsigned ST_SIZE_LSB = 5;

    localparam int unsigned FAULT_REFUSED_BIT = 0;
    localparam int unsigned FAULT_TIMEOUT_BIT = 1;
    localparam logic [1:0] FAULT_RESET = 2'h0;

    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam logic [2:0] POST_WRITE_CYCLES = 3'h1;
    localparam logic [PC_W-1:0] ADDR_ZERO = 13'h0000;

    // Fuse and lock settings; a one means programmed.
    typedef struct packed {
        logic boot_reset_fuse;
        logic [1:0] boot_size_fuses;
        logic app_area_boot_lock;
        logic boot_area_boot_lock;
    } fuse_s;

    localparam fuse_s FUSE_RESET = '{1'b0, 2'h0, 1'b0, 1'b0};

    typedef struct packed {
        logic [PC_W-1:0] reset_addr;
        logic [PC_W-1:0] vector_base;
        logic [PC_W-1:0] vector_addr;
        logic in_boot;
    } map_s;

    localparam map_s MAP_RESET = '{ADDR_ZERO, ADDR_ZERO, ADDR_ZERO, 1'b0};

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ARMED = 2'b01,
        SEQ_HOLD = 2'b11
    } seq_state_e;

endpackage

/* File: tb.sv */
// Bench for the vector placement block driven over APB.
// Assumes one wait state per transfer and fuses changed only in reset.
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int FW = 8192;
    localparam int BM = 128;
    localparam logic [11:0] GIC = ivr_pkg::GIC_OFFSET;
    localparam logic [11:0] FLT = ivr_pkg::FAULT_OFFSET;
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, dis, gie, boot_q = 0, gie_q = 1;
    logic [2:0] ext;
    logic [12:0] pc, rva, vba, va, bs;
    logic [4:0] idx, num_q = 5'h01;
    ivr_pkg::fuse_s fuses = ivr_pkg::FUSE_RESET;
    int fail_count = 0, num_checks = 0;
    time rel_t = '1;
    assign bs = 13'(FW - (BM << (2'h3 - fuses.boot_size_fuses)));
    always #12.5 mclk = ~mclk;
    vector_relocation #(.FLASH_WORDS(FW), .BOOT_MIN_WORDS(BM)) dut (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fuses(fuses),
        .global_irq_enable(gie), .exec_pc(pc), .vector_index(idx),
        .dispatch_allow_q(dis), .ext_irq_enable_q(ext),
        .reset_vector_addr(rva), .vector_base_addr(vba), .vector_addr(va));
    core_model core (.mclk(mclk), .reset(reset), .run_in_boot(boot_q),
        .irq_on(gie_q), .irq_num(num_q), .boot_start(bs), .exec_pc(pc),
        .vector_index(idx), .global_irq_enable(gie));
    task automatic chk(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic hold);
        int n;
        n = 0;
        if (rel_t == $time) begin
            @(posedge mclk);
        end
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk(32'(n < 16), 32'h1, "ready");
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
        if (!hold) begin
            psel <= 1'b0;
            rel_t = $time;
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
        input logic experr);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(rd, exp, "read");
        chk(32'(er), 32'(experr), "slverr");
    endtask
    task automatic rst(input ivr_pkg::fuse_s f);
        reset <= 1'b1;
        fuses <= f;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        idle(4000);
        fail_count++;
        conclude();
    end
    initial begin
        rst(ivr_pkg::FUSE_RESET);
        rdchk(GIC, 32'h0, 1'b0);
        rdchk(12'h00c, 32'h0, 1'b1);
        chk(va, 32'h2, "vector");
        chk(rva, 32'h0, "reset addr");
        $display("end reset test");
        gie_q <= 1'b0;
        idle(3);
        chk(dis, 32'h0, "flag off");
        gie_q <= 1'b1;
        apb(1'b1, GIC, 32'h2, 1'b0);
        idle(3);
        chk(vba, 32'h0, "base");
        rdchk(GIC, 32'h0, 1'b0);
        rdchk(FLT, 32'h1, 1'b0);
        apb(1'b1, FLT, 32'h1, 1'b0);
        $display("end refused test");
        apb(1'b1, GIC, 32'h1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            idle(1);
            chk(dis, 32'h0, "blocked");
        end
        idle(3);
        chk(dis, 32'h1, "resumed");
        rdchk(GIC, 32'h0, 1'b0);
        rdchk(FLT, 32'h2, 1'b0);
        apb(1'b1, FLT, 32'h3, 1'b0);
        $display("end timeout test");
        apb(1'b1, GIC, 32'he1, 1'b1);
        apb(1'b1, GIC, 32'he2, 1'b0);
        chk(dis, 32'h0, "blocked");
        idle(1);
        chk(dis, 32'h0, "blocked");
        idle(3);
        chk(dis, 32'h1, "resumed");
        chk(32'(ext), 32'h7, "enables");
        rdchk(GIC, 32'he2, 1'b0);
        chk(vba, 32'h1c00, "base");
        for (int i = 1; i <= 20; i += 19) begin
            num_q <= i[4:0];
            idle(3);
            chk(va, 32'h1c00 + 32'(2 * i), "vector");
        end
        $display("end move test");
        for (int s = 0; s < 4; s++) begin
            rst('{1'b1, s[1:0], 1'b1, 1'b1});
            chk(rva, 32'(FW - (BM << (3 - s))), "reset addr");
        end
        rst('{1'b1, 2'h0, 1'b1, 1'b1});
        num_q <= 5'h01;
        idle(3);
        chk(rva, 32'h1c00, "reset addr");
        chk(va, 32'h2, "vector");
        boot_q <= 1'b1;
        idle(4);
        chk(dis, 32'h0, "boot lock");
        boot_q <= 1'b0;
        idle(4);
        chk(dis, 32'h1, "app free");
        apb(1'b1, GIC, 32'h1, 1'b1);
        apb(1'b1, GIC, 32'h2, 1'b0);
        idle(4);
        chk(dis, 32'h0, "app lock");
        rdchk(ivr_pkg::STATUS_OFFSET, 32'h15, 1'b0);
        boot_q <= 1'b1;
        idle(4);
        chk(dis, 32'h1, "boot free");
        $display("end lock test");
        conclude();
    end
endmodule
bind vector_relocation ivr_monitor #(.FLASH_WORDS(FLASH_WORDS),
    .BOOT_MIN_WORDS(BOOT_MIN_WORDS)) mon (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .fuses(fuses),
    .global_irq_enable(global_irq_enable), .exec_pc(exec_pc),
    .vector_index(vector_index), .dispatch_allow_q(dispatch_allow_q),
    .reset_vector_addr(reset_vector_addr),
    .vector_base_addr(vector_base_addr), .vector_addr(vector_addr));
`default_nettype wire

/* File: unlock_sequencer.sv */
// Timed two-step unlock for moving the vector table.
// Assumes arm and select_write are one-cycle pulses from the register file.
`timescale 1ns/10ps
`default_nettype none
module unlock_sequencer (
    input wire logic mclk,
    input wire logic reset,
    input wire logic arm,
    input wire logic select_write,
    output logic armed_q,
    output logic block_next,
    output logic timeout_q
);

    ivr_pkg::seq_state_e state_q;
    ivr_pkg::seq_state_e state_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (arm) begin
            state_d = ivr_pkg::SEQ_ARMED;
            cnt_d = ivr_pkg::UNLOCK_CYCLES - 3'h1;
        end else begin
            unique case (state_q)
                ivr_pkg::SEQ_IDLE: begin
                    cnt_d = 3'h0;
                end
                ivr_pkg::SEQ_ARMED: begin
                    if (select_write) begin
                        state_d = ivr_pkg::SEQ_HOLD;
                        cnt_d = ivr_pkg::POST_WRITE_CYCLES - 3'h1;
                    end else if (cnt_q == 3'h0) begin
                        state_d = ivr_pkg::SEQ_IDLE;
                    end else begin
                        cnt_d = cnt_q - 3'h1;
                    end
                end
                ivr_pkg::SEQ_HOLD: begin
                    if (cnt_q == 3'h0) begin
                        state_d = ivr_pkg::SEQ_IDLE;
                    end else begin
                        cnt_d = cnt_q - 3'h1;
                    end
                end
                default: begin
                    state_d = ivr_pkg::SEQ_IDLE;
                    cnt_d = 3'h0;
                end
            endcase
        end
    end

    // Blocking starts with the same edge that sets the unlock bit.
    assign block_next = (state_d != ivr_pkg::SEQ_IDLE);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= ivr_pkg::SEQ_IDLE;
            cnt_q <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            armed_q <= 1'b0;
            timeout_q <= 1'b0;
        end else begin
            armed_q <= (state_d == ivr_pkg::SEQ_ARMED);
            timeout_q <= !arm && state_q == ivr_pkg::SEQ_ARMED
                && !select_write && cnt_q == 3'h0;
        end
    end

endmodule
`default_nettype wire

/* File: vector_relocation.sv */
// Vector table placement control with its APB register file.
// Assumes the core honours dispatch_allow_q and supplies its fetch address.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module vector_relocation #(
    parameter int unsigned FLASH_WORDS = ivr_pkg::FLASH_WORDS_DEF,
    parameter int unsigned BOOT_MIN_WORDS = ivr_pkg::BOOT_MIN_WORDS_DEF
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ivr_pkg::fuse_s fuses,
    input wire logic global_irq_enable,
    input wire logic [ivr_pkg::PC_W-1:0] exec_pc,
    input wire logic [ivr_pkg::INDEX_W-1:0] vector_index,
    output logic dispatch_allow_q,
    output logic [2:0] ext_irq_enable_q,
    output logic [ivr_pkg::PC_W-1:0] reset_vector_addr,
    output logic [ivr_pkg::PC_W-1:0] vector_base_addr,
    output logic [ivr_pkg::PC_W-1:0] vector_addr
);

    ivr_pkg::fuse_s fuse_q;
    ivr_pkg::map_s map_q;
    logic fuse_taken_q;
    logic select_q;
    logic [1:0] fault_q;
    logic armed_q;
    logic block_next;
    logic timeout_q;
    logic seq_block_q;
    logic lock_block_q;
    logic lock_block;
    logic access;
    logic done;
    logic write_gic;
    logic write_fault;
    logic arm;
    logic select_write;
    logic refused;
    logic [7:0] gic_view;
    logic [7:0] status_view;
    logic [31:0] read_d;
    logic mapped;

    // Fuses are caught once, on the first edge after reset is released.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fuse_q <= ivr_pkg::FUSE_RESET;
            fuse_taken_q <= 1'b0;
        end else if (!fuse_taken_q) begin
            fuse_q <= fuses;
            fuse_taken_q <= 1'b1;
        end
    end

    // Bus decode; one wait state, the write lands at the completing edge.
    assign access = psel && penable;
    assign done = access && pready;
    assign write_gic = done && pwrite && paddr == ivr_pkg::GIC_OFFSET;
    assign write_fault = done && pwrite && paddr == ivr_pkg::FAULT_OFFSET;
    assign arm = write_gic && pwdata[ivr_pkg::UNLOCK_BIT];
    assign select_write = write_gic && !pwdata[ivr_pkg::UNLOCK_BIT]
        && armed_q;
    assign refused = write_gic && !pwdata[ivr_pkg::UNLOCK_BIT] && !armed_q
        && pwdata[ivr_pkg::SELECT_BIT] != select_q;

    always_comb begin
        mapped = 1'b1;
        unique case (paddr)
            ivr_pkg::GIC_OFFSET: begin
                mapped = 1'b1;
            end
            ivr_pkg::STATUS_OFFSET: begin
                mapped = 1'b1;
            end
            ivr_pkg::FAULT_OFFSET: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    unlock_sequencer u_unlock (
        .mclk(mclk),
        .reset(reset),
        .arm(arm),
        .select_write(select_write),
        .armed_q(armed_q),
        .block_next(block_next),
        .timeout_q(timeout_q)
    );

    // Placement changes only inside the unlock window.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            select_q <= ivr_pkg::GIC_RESET[ivr_pkg::SELECT_BIT];
        end else if (select_write) begin
            select_q <= pwdata[ivr_pkg::SELECT_BIT];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ext_irq_enable_q <= ivr_pkg::GIC_RESET[7:5];
        end else if (write_gic) begin
            ext_irq_enable_q <= pwdata[7:5];
        end
    end

    // Sticky faults; a new event wins over a write-one clear.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fault_q <= ivr_pkg::FAULT_RESET;
        end else begin
            fault_q <= (fault_q & ~(write_fault ? pwdata[1:0] : 2'h0))
                | {timeout_q, refused};
        end
    end

    boot_map #(
        .FLASH_WORDS(FLASH_WORDS),
        .BOOT_MIN_WORDS(BOOT_MIN_WORDS)
    ) u_map (
        .mclk(mclk),
        .reset(reset),
        .fuses(fuse_q),
        .select(select_q),
        .exec_pc(exec_pc),
        .vector_index(vector_index),
        .map_q(map_q)
    );

    assign reset_vector_addr = map_q.reset_addr;
    assign vector_base_addr = map_q.vector_base;
    assign vector_addr = map_q.vector_addr;

    // Lock-driven masking depends on where code runs.
    assign lock_block = (select_q && fuse_q.app_area_boot_lock
        && !map_q.in_boot)
        || (!select_q && fuse_q.boot_area_boot_lock
        && map_q.in_boot);

    // The global enable only passes through; it is never written here.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dispatch_allow_q <= 1'b0;
            seq_block_q <= 1'b0;
            lock_block_q <= 1'b0;
        end else begin
            dispatch_allow_q <= global_irq_enable && !block_next
                && !lock_block;
            seq_block_q <= block_next;
            lock_block_q <= lock_block;
        end
    end

    assign gic_view = {ext_irq_enable_q, 3'h0, select_q, armed_q};

    always_comb begin
        status_view = 8'h00;
        status_view[ivr_pkg::ST_BLOCK_BIT] = seq_block_q || lock_block_q;
        status_view[ivr_pkg::ST_SEQ_BIT] = seq_block_q;
        status_view[ivr_pkg::ST_LOCK_BIT] = lock_block_q;
        status_view[ivr_pkg::ST_IN_BOOT_BIT] = map_q.in_boot;
        status_view[ivr_pkg::ST_BOOT_RESET_BIT] = fuse_q.boot_reset_fuse;
        status_view[ivr_pkg::ST_SIZE_LSB +: 2] = fuse_q.boot_size_fuses;
    end

    always_comb begin
        read_d = 32'h0000_0000;
        unique case (paddr)
            ivr_pkg::GIC_OFFSET: begin
                read_d = {24'h00_0000, gic_view};
            end
            ivr_pkg::STATUS_OFFSET: begin
                read_d = {24'h00_0000, status_view};
            end
            ivr_pkg::FAULT_OFFSET: begin
                read_d = {30'h0000_0000, fault_q};
            end
            default: begin
                read_d = 32'h0000_0000;
            end
        endcase
    end

    // Answer in the second access cycle; unmapped addresses give an error.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (access && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? 32'h0000_0000 : read_d;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire
